//--- rtl/exec_regs.vh
// Constants for the bit, flag and load/store execution block
// Function
// - I/O bit set/clear, one cycle, flags kept
// - Bit store copies register bit to T
// - Bit load writes T into register bit
// - Flag set/clear touches one flag only
// - Indirect load 1/2 cycles, post-increment 2
// - Pre-decrement load: decrement, then read; 2/3
// - Plain/post-increment store finishes in one cycle
// - Pre-decrement store: decrement and write together; 2
// - Direct load reads constant address, one cycle
// - Direct store writes constant address, one cycle
// - I/O in and out, one cycle each
// - Push stores register on stack, 2 cycles
// - Pop loads register from stack, 2 cycles
// - Break, idle, sleep, watchdog restart: one cycle
`ifndef EXEC_REGS_VH
`define EXEC_REGS_VH

// Operation codes on the op_code input
`define OP_IDLE 5'h00
`define OP_IO_BIT_SET 5'h01
`define OP_IO_BIT_CLEAR 5'h02
`define OP_BIT_TO_FLAG 5'h03
`define OP_FLAG_TO_BIT 5'h04
`define OP_FLAG_SET 5'h05
`define OP_FLAG_CLEAR 5'h06
`define OP_REG_COPY 5'h07
`define OP_IMMEDIATE_LOAD 5'h08
`define OP_INDIRECT_LOAD 5'h09
`define OP_INDIRECT_STORE 5'h0a
`define OP_DIRECT_LOAD 5'h0b
`define OP_DIRECT_STORE 5'h0c
`define OP_IO_IN 5'h0d
`define OP_IO_OUT 5'h0e
`define OP_PUSH 5'h0f
`define OP_POP 5'h10
`define OP_BREAK 5'h11
`define OP_SLEEP 5'h12
`define OP_WATCHDOG_RESTART 5'h13

// Pointer update modes
`define PTR_PLAIN 2'h0
`define PTR_POST_INC 2'h1
`define PTR_PRE_DEC 2'h2

// Pointer selects and their low register index
`define PTR_X 2'h0
`define PTR_Y 2'h1
`define PTR_Z 2'h2
`define PTR_X_LO 4'ha
`define PTR_Y_LO 4'hc
`define PTR_Z_LO 4'he

// Status flag bit positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

// Reset values and memory map
`define FLAGS_RESET 8'h00
`define REG_RESET 8'h00
`define SP_RESET 16'h00bf
`define DATA_MEM_BASE 16'h0040

`endif

//--- rtl/work_reg_file.v
// Working register file, two read ports and two write ports
`timescale 1ns/1ps
`default_nettype none
module work_reg_file #(
	parameter COUNT = 16
) (
	input wire sys_clk,
	input wire rst_n,
	input wire [3:0] rd_a_idx,
	output wire [7:0] rd_a_data,
	input wire [3:0] rd_b_idx,
	output wire [7:0] rd_b_data,
	input wire wr_a_en,
	input wire [3:0] wr_a_idx,
	input wire [7:0] wr_a_data,
	input wire wr_b_en,
	input wire [3:0] wr_b_idx,
	input wire [7:0] wr_b_data
);
`include "exec_regs.vh"
	reg [7:0] regs_ff [0:COUNT-1];
	integer i;

	assign rd_a_data = regs_ff[rd_a_idx];
	assign rd_b_data = regs_ff[rd_b_idx];

	// Port b wins a clash; it carries pointer updates
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < COUNT; i = i + 1)
				regs_ff[i] <= `REG_RESET;
		end else begin
			for (i = 0; i < COUNT; i = i + 1) begin
				if (wr_b_en && wr_b_idx == i[3:0])
					regs_ff[i] <= wr_b_data;
				else if (wr_a_en && wr_a_idx == i[3:0])
					regs_ff[i] <= wr_a_data;
			end
		end
	end
endmodule // work_reg_file
`default_nettype wire

//--- rtl/status_flags.v
// Status flag register with single-flag set/clear and T bit load
`timescale 1ns/1ps
`default_nettype none
module status_flags (
	input wire sys_clk,
	input wire rst_n,
	input wire flag_wr,
	input wire [2:0] flag_sel,
	input wire flag_val,
	output wire [7:0] status_flags_reg
);
`include "exec_regs.vh"
	reg [7:0] flags_ff;
	assign status_flags_reg = flags_ff;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			flags_ff <= `FLAGS_RESET;
		else if (flag_wr)
			flags_ff[flag_sel] <= flag_val;
	end
endmodule // status_flags
`default_nettype wire

//--- rtl/bit_flag_and_load_store_exec.v
// Execute path for bit, flag, data transfer and control operations
`timescale 1ns/1ps
`default_nettype none
module bit_flag_and_load_store_exec (
	input wire sys_clk,
	input wire rst_n,
	// Decoded operation from fetch
	input wire op_valid,
	input wire [4:0] op_code,
	input wire [3:0] dst_idx,
	input wire [3:0] src_idx,
	input wire [2:0] bit_sel,
	input wire [7:0] imm_val,
	input wire [15:0] addr_val,
	input wire [5:0] io_addr,
	input wire [1:0] ptr_sel,
	input wire [1:0] ptr_mode,
	output wire op_ready,
	output reg op_done,
	// Data space
	output reg [15:0] mem_addr,
	output reg [7:0] mem_wdata,
	output reg mem_wr,
	output reg mem_rd,
	input wire [7:0] mem_rdata,
	// I/O space
	output reg [5:0] io_addr_out,
	output reg [7:0] io_wdata,
	output reg io_wr,
	output reg io_rd,
	input wire [7:0] io_rdata,
	// Control effects
	output reg break_pulse,
	output reg sleep_pulse,
	output reg watchdog_restart_pulse,
	output wire [7:0] status_flags_reg,
	output wire [15:0] stack_ptr
);
`include "exec_regs.vh"
	localparam ST_ISSUE = 2'h0;
	localparam ST_ACCESS = 2'h1;
	localparam ST_FINISH = 2'h2;

	reg [1:0] state_ff, nxt_state;
	reg [4:0] op_ff;
	reg [3:0] dst_ff;
	reg [15:0] addr_ff;
	reg is_io_ff;
	reg [15:0] sp_ff;
	reg [15:0] nxt_sp;

	wire [7:0] rd_a_data;
	wire [7:0] rd_b_data;
	reg [3:0] rd_a_idx, rd_b_idx;
	reg wr_a_en, wr_b_en;
	reg [3:0] wr_a_idx, wr_b_idx;
	reg [7:0] wr_a_data, wr_b_data;
	reg flag_wr, flag_val;
	reg [2:0] flag_sel;
	// Shadow of the pointer pairs: a store needs pointer and data in one cycle
	reg [7:0] pair_ff [0:5];
	wire [3:0] ptr_lo;
	wire [2:0] pair_lo;
	wire take;
	reg pend_ff;
	reg [3:0] pend_dst_ff;
	reg pend_io_ff;
	integer j;
	reg [15:0] ptr_val, ptr_new;

	////////////////////////////////////////////////////////////////
	function [3:0] ptr_lo_idx;
		input [1:0] sel;
		begin
			if (sel == `PTR_Y)
				ptr_lo_idx = `PTR_Y_LO;
			else if (sel == `PTR_Z)
				ptr_lo_idx = `PTR_Z_LO;
			else
				ptr_lo_idx = `PTR_X_LO;
		end
	endfunction

	// Below the data-memory base the access lands in register/I/O space
	function in_data_mem;
		input [15:0] a;
		begin
			in_data_mem = (a >= `DATA_MEM_BASE);
		end
	endfunction

	work_reg_file #(.COUNT(16)) u_regs (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.rd_a_idx(rd_a_idx),
		.rd_a_data(rd_a_data),
		.rd_b_idx(rd_b_idx),
		.rd_b_data(rd_b_data),
		.wr_a_en(wr_a_en),
		.wr_a_idx(wr_a_idx),
		.wr_a_data(wr_a_data),
		.wr_b_en(wr_b_en),
		.wr_b_idx(wr_b_idx),
		.wr_b_data(wr_b_data)
	);

	status_flags u_flags (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.flag_wr(flag_wr),
		.flag_sel(flag_sel),
		.flag_val(flag_val),
		.status_flags_reg(status_flags_reg)
	);

	// Held off for one cycle while a single-cycle load result lands
	assign op_ready = (state_ff == ST_ISSUE) && !pend_ff;
	assign take = op_ready && op_valid;
	assign ptr_lo = ptr_lo_idx(ptr_sel);
	assign pair_lo = ptr_lo[2:0] - 3'h2;
	assign stack_ptr = sp_ff;

	////////////////////////////////////////////////////////////////
	// Pointer is a register pair; both bytes come from the pair shadow
	always @* begin
		ptr_val = {pair_ff[pair_lo + 3'h1], pair_ff[pair_lo]};
		ptr_new = ptr_val;
		if (ptr_mode == `PTR_POST_INC)
			ptr_new = ptr_val + 16'h0001;
		else if (ptr_mode == `PTR_PRE_DEC)
			ptr_new = ptr_val - 16'h0001;
	end

	always @* begin
		nxt_state = state_ff;
		nxt_sp = sp_ff;
		rd_a_idx = src_idx;
		rd_b_idx = dst_idx;
		wr_a_en = 1'b0;
		wr_a_idx = dst_idx;
		wr_a_data = rd_a_data;
		wr_b_en = 1'b0;
		wr_b_idx = 4'h0;
		wr_b_data = 8'h00;
		flag_wr = 1'b0;
		flag_sel = bit_sel;
		flag_val = 1'b0;
		if (take) begin
			case (op_code)
				`OP_BIT_TO_FLAG: begin
					flag_wr = 1'b1;
					flag_sel = `FLAG_T;
					flag_val = rd_a_data[bit_sel];
				end
				`OP_FLAG_TO_BIT: begin
					rd_a_idx = dst_idx;
					wr_a_en = 1'b1;
					wr_a_data = rd_a_data;
					wr_a_data[bit_sel] = status_flags_reg[`FLAG_T];
				end
				`OP_FLAG_SET: begin
					flag_wr = 1'b1;
					flag_val = 1'b1;
				end
				`OP_FLAG_CLEAR: begin
					flag_wr = 1'b1;
					flag_val = 1'b0;
				end
				`OP_REG_COPY: begin
					wr_a_en = 1'b1;
				end
				`OP_IMMEDIATE_LOAD: begin
					wr_a_en = 1'b1;
					wr_a_data = imm_val;
				end
				`OP_INDIRECT_LOAD, `OP_INDIRECT_STORE: begin
					if (ptr_mode != `PTR_PLAIN) begin
						// Low byte on port a, high byte on port b in the same cycle
						wr_a_en = 1'b1;
						wr_a_idx = ptr_lo_idx(ptr_sel);
						wr_a_data = ptr_new[7:0];
						wr_b_en = 1'b1;
						wr_b_idx = ptr_lo_idx(ptr_sel) + 4'h1;
						wr_b_data = ptr_new[15:8];
					end
				end
				`OP_POP: begin
					nxt_sp = sp_ff + 16'h0001;
				end
				`OP_PUSH: begin
					nxt_sp = sp_ff - 16'h0001;
				end
				default: begin
				end
			endcase
			// Multi-cycle operations leave issue state
			if (op_code == `OP_INDIRECT_LOAD) begin
				if (ptr_mode == `PTR_PLAIN && !in_data_mem(ptr_val))
					nxt_state = ST_ISSUE;
				else if (ptr_mode == `PTR_PRE_DEC && in_data_mem(ptr_new))
					nxt_state = ST_ACCESS;
				else
					nxt_state = ST_FINISH;
			end else if (op_code == `OP_INDIRECT_STORE && ptr_mode == `PTR_PRE_DEC) begin
				nxt_state = ST_FINISH;
			end else if (op_code == `OP_PUSH || op_code == `OP_POP) begin
				nxt_state = ST_FINISH;
			end
		end else if (state_ff == ST_ACCESS) begin
			nxt_state = ST_FINISH;
		end else if (state_ff == ST_FINISH) begin
			nxt_state = ST_ISSUE;
			if (op_ff == `OP_INDIRECT_LOAD || op_ff == `OP_POP) begin
				wr_a_en = 1'b1;
				wr_a_idx = dst_ff;
				wr_a_data = is_io_ff ? io_rdata : mem_rdata;
			end
		end
		// Deferred single-cycle load result
		if (pend_ff) begin
			wr_b_en = 1'b1;
			wr_b_idx = pend_dst_ff;
			wr_b_data = pend_io_ff ? io_rdata : mem_rdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// Bus strobes and one-cycle answers
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_ISSUE;
			op_ff <= `OP_IDLE;
			dst_ff <= 4'h0;
			addr_ff <= 16'h0000;
			is_io_ff <= 1'b0;
			sp_ff <= `SP_RESET;
			op_done <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 8'h00;
			mem_wr <= 1'b0;
			mem_rd <= 1'b0;
			io_addr_out <= 6'h00;
			io_wdata <= 8'h00;
			io_wr <= 1'b0;
			io_rd <= 1'b0;
			break_pulse <= 1'b0;
			sleep_pulse <= 1'b0;
			watchdog_restart_pulse <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			sp_ff <= nxt_sp;
			mem_wr <= 1'b0;
			mem_rd <= 1'b0;
			io_wr <= 1'b0;
			io_rd <= 1'b0;
			break_pulse <= 1'b0;
			sleep_pulse <= 1'b0;
			watchdog_restart_pulse <= 1'b0;
			op_done <= (nxt_state == ST_ISSUE) && (state_ff != ST_ISSUE || take);
			if (take) begin
				op_ff <= op_code;
				dst_ff <= dst_idx;
				is_io_ff <= 1'b0;
				case (op_code)
					`OP_IO_BIT_SET, `OP_IO_BIT_CLEAR, `OP_IO_IN, `OP_IO_OUT: begin
						io_addr_out <= io_addr;
						is_io_ff <= 1'b1;
						io_rd <= (op_code == `OP_IO_IN);
						io_wr <= (op_code != `OP_IO_IN);
						// Bit ops write the current value with one bit forced
						io_wdata <= (op_code == `OP_IO_OUT) ? rd_a_data :
							(op_code == `OP_IO_BIT_SET) ? (io_rdata | (8'h01 << bit_sel)) :
							(io_rdata & ~(8'h01 << bit_sel));
					end
					`OP_DIRECT_LOAD: begin
						mem_addr <= addr_val;
						mem_rd <= 1'b1;
					end
					`OP_DIRECT_STORE: begin
						mem_addr <= addr_val;
						mem_wdata <= rd_a_data;
						mem_wr <= 1'b1;
					end
					`OP_INDIRECT_LOAD: begin
						mem_addr <= (ptr_mode == `PTR_PRE_DEC) ? ptr_new : ptr_val;
						// Pre-decrement in data memory reads after the decrement cycle
						mem_rd <= (nxt_state != ST_ACCESS);
					end
					`OP_INDIRECT_STORE: begin
						mem_addr <= (ptr_mode == `PTR_PRE_DEC) ? ptr_new : ptr_val;
						mem_wdata <= rd_a_data;
						mem_wr <= 1'b1;
					end
					`OP_PUSH: begin
						mem_addr <= sp_ff;
						mem_wdata <= rd_a_data;
						mem_wr <= 1'b1;
					end
					`OP_POP: begin
						mem_addr <= sp_ff + 16'h0001;
						mem_rd <= 1'b1;
					end
					`OP_BREAK: break_pulse <= 1'b1;
					`OP_SLEEP: sleep_pulse <= 1'b1;
					`OP_WATCHDOG_RESTART: watchdog_restart_pulse <= 1'b1;
					default: begin
					end
				endcase
			end else if (state_ff == ST_ACCESS) begin
				mem_rd <= 1'b1;
			end
		end
	end

	// Single-cycle loads land one edge later, holding off the next issue
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_ff <= 1'b0;
			pend_dst_ff <= 4'h0;
			pend_io_ff <= 1'b0;
		end else begin
			pend_ff <= take && nxt_state == ST_ISSUE &&
				(op_code == `OP_DIRECT_LOAD || op_code == `OP_IO_IN || op_code == `OP_INDIRECT_LOAD);
			pend_dst_ff <= dst_idx;
			pend_io_ff <= (op_code == `OP_IO_IN);
		end
	end

	// Pointer shadow follows both write ports, port b first as in the file
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (j = 0; j < 6; j = j + 1)
				pair_ff[j] <= `REG_RESET;
		end else begin
			for (j = 0; j < 6; j = j + 1) begin
				if (wr_b_en && wr_b_idx == j[3:0] + `PTR_X_LO)
					pair_ff[j] <= wr_b_data;
				else if (wr_a_en && wr_a_idx == j[3:0] + `PTR_X_LO)
					pair_ff[j] <= wr_a_data;
			end
		end
	end
endmodule // bit_flag_and_load_store_exec
`default_nettype wire

//--- testbench/exec_chk.sv
// Port checker for the bit, flag and load/store execute block
`timescale 1ns/1ps
`default_nettype none
`include "exec_regs.vh"
module exec_chk (
	input wire sys_clk,
	input wire rst_n,
	input wire op_valid,
	input wire [4:0] op_code,
	input wire [2:0] bit_sel,
	input wire [15:0] addr_val,
	input wire [5:0] io_addr,
	input wire [1:0] ptr_mode,
	input wire op_ready,
	input wire op_done,
	input wire [15:0] mem_addr,
	input wire mem_wr,
	input wire [7:0] io_wdata,
	input wire io_wr,
	input wire [7:0] io_rdata,
	input wire break_pulse,
	input wire sleep_pulse,
	input wire [7:0] status_flags_reg,
	input wire [15:0] stack_ptr
);
	wire tk = op_valid && op_ready;
	wire [7:0] msk = 8'h01 << bit_sel;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	property p_flag_set;
		tk && op_code == `OP_FLAG_SET |=> op_done && status_flags_reg == ($past(status_flags_reg) | $past(msk));
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag set wrong");
	property p_flag_clr;
		tk && op_code == `OP_FLAG_CLEAR |=> op_done && status_flags_reg == ($past(status_flags_reg) & ~$past(msk));
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag clear wrong");
	property p_bit_flag;
		tk && op_code == `OP_BIT_TO_FLAG |=> op_done && (status_flags_reg & 8'hbf) == ($past(status_flags_reg) & 8'hbf);
	endproperty
	a_bit_flag: assert property (p_bit_flag) else $error("bit store touched other flags");
	property p_io_set;
		tk && op_code == `OP_IO_BIT_SET |=> op_done && io_wr && io_wdata == ($past(io_rdata) | $past(msk));
	endproperty
	a_io_set: assert property (p_io_set) else $error("io bit set wrong");
	property p_io_clr;
		tk && op_code == `OP_IO_BIT_CLEAR |=> io_wr && io_wdata == ($past(io_rdata) & ~$past(msk)) && $stable(status_flags_reg);
	endproperty
	a_io_clr: assert property (p_io_clr) else $error("io bit clear wrong");
	property p_dir_st;
		tk && op_code == `OP_DIRECT_STORE |=> op_done && mem_wr && mem_addr == $past(addr_val);
	endproperty
	a_dir_st: assert property (p_dir_st) else $error("direct store wrong");
	property p_push;
		tk && op_code == `OP_PUSH |=> mem_wr && mem_addr == $past(stack_ptr) && !op_done ##1 op_done;
	endproperty
	a_push: assert property (p_push) else $error("push wrong");
	property p_pop;
		tk && op_code == `OP_POP |=> !op_done ##1 op_done && stack_ptr == $past(stack_ptr, 2) + 16'h0001;
	endproperty
	a_pop: assert property (p_pop) else $error("pop wrong");
	property p_pre_st;
		tk && op_code == `OP_INDIRECT_STORE && ptr_mode == `PTR_PRE_DEC |=> mem_wr && !op_done ##1 op_done;
	endproperty
	a_pre_st: assert property (p_pre_st) else $error("pre-decrement store wrong");
	property p_brk;
		tk && op_code == `OP_BREAK |=> op_done && break_pulse && !sleep_pulse && $stable(status_flags_reg);
	endproperty
	a_brk: assert property (p_brk) else $error("break wrong");
	c_push: cover property (tk && op_code == `OP_PUSH);
	c_pre_ld: cover property (tk && op_code == `OP_INDIRECT_LOAD && ptr_mode == `PTR_PRE_DEC);
	c_io_set: cover property (tk && op_code == `OP_IO_BIT_SET);
endmodule // exec_chk
bind bit_flag_and_load_store_exec exec_chk chk_i (.*);
`default_nettype wire

//--- testbench/exec_mem_model.sv
// Data space and I/O space model facing the execute block
`timescale 1ns/1ps
`default_nettype none
module exec_mem_model (
	input wire sys_clk,
	input wire [15:0] mem_addr,
	input wire [7:0] mem_wdata,
	input wire mem_wr,
	input wire mem_rd,
	output logic [7:0] mem_rdata,
	input wire [5:0] io_addr,
	input wire [5:0] io_addr_out,
	input wire [7:0] io_wdata,
	input wire io_wr,
	output logic [7:0] io_rdata
);
	// Only the low address byte decodes, enough for the stack and test area
	logic [7:0] dmem [0:255];
	logic [7:0] iom [0:63];
	logic [7:0] tog;
	initial tog = 8'h5a;
	assign io_rdata = iom[io_addr];
	// Answers while the read strobe stands; toggles otherwise so a stray sample cannot match
	assign mem_rdata = mem_rd ? dmem[mem_addr[7:0]] : tog;
	always @(posedge sys_clk) begin
		if (mem_wr) dmem[mem_addr[7:0]] <= mem_wdata;
		if (io_wr) iom[io_addr_out] <= io_wdata;
		tog <= ~tog;
	end
endmodule // exec_mem_model
`default_nettype wire

//--- testbench/bit_flag_and_load_store_exec_bench.sv
// Self-checking bench for the execute block
`timescale 1ns/1ps
`default_nettype none
`include "exec_regs.vh"
module bit_flag_and_load_store_exec_bench;
	logic sys_clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0;
	logic [4:0] op_code = 5'h00;
	logic [3:0] dst_idx = 4'h0, src_idx = 4'h0;
	logic [2:0] bit_sel = 3'h0;
	logic [7:0] imm_val = 8'h00;
	logic [15:0] addr_val = 16'h0000;
	logic [5:0] io_addr = 6'h00;
	logic [1:0] ptr_sel = `PTR_X, ptr_mode = 2'h0;
	wire op_ready, op_done, mem_wr, mem_rd, io_wr, io_rd, break_pulse, sleep_pulse, watchdog_restart_pulse;
	wire [15:0] mem_addr, stack_ptr;
	wire [7:0] mem_wdata, mem_rdata, io_wdata, io_rdata, status_flags_reg;
	wire [5:0] io_addr_out;
	logic [23:0] w;
	logic [15:0] ra;
	logic [7:0] iod;
	logic [2:0] pl;
	int checks = 0, n_mismatch = 0;
	bit_flag_and_load_store_exec uut (.*);
	exec_mem_model mem_i (.*);
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [23:0] s, input logic [23:0] e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// One register index feeds both ports; low bits of b double as pointer mode
	task automatic run(input logic [4:0] c, input logic [3:0] r, input logic [2:0] b, input logic [7:0] k,
		input logic [15:0] a, input int ex);
		int n;
		w = 'x;
		ra = 'x;
		iod = 'x;
		pl = 3'h0;
		@(posedge sys_clk);
		op_valid <= 1'b1;
		{op_code, dst_idx, src_idx, bit_sel, imm_val, addr_val, io_addr, ptr_mode} <= {c, r, r, b, k, a, a[5:0], b[1:0]};
		@(posedge sys_clk);
		op_valid <= 1'b0;
		for (n = 1; n < 9; n++) begin
			#1;
			if (mem_wr === 1'b1) w = {mem_addr, mem_wdata};
			if (mem_rd === 1'b1) ra = mem_addr;
			if (io_wr === 1'b1) iod = io_wdata;
			pl = pl | {break_pulse, sleep_pulse, watchdog_restart_pulse};
			if (op_done === 1'b1) break;
			@(posedge sys_clk);
		end
		if (n == 9) begin
			n_mismatch++;
			final_report();
		end
		chk("cycles", n[23:0], ex[23:0]);
	endtask
	////////////////////////////////////////////////////////////////
	task t_flags;
		logic [7:0] e;
		e = 8'h00;
		for (int i = 0; i < 16; i++) begin
			run(i < 8 ? `OP_FLAG_SET : `OP_FLAG_CLEAR, 4'h0, 3'(i), 8'h00, 16'h0000, 1);
			e[i % 8] = i < 8;
			chk("flags", status_flags_reg, e);
		end
	endtask
	task t_bits;
		run(`OP_IMMEDIATE_LOAD, 4'h1, 3'h0, 8'h04, 16'h0000, 1);
		run(`OP_BIT_TO_FLAG, 4'h1, 3'h2, 8'h00, 16'h0000, 1);
		chk("t flag", status_flags_reg, 8'h40);
		run(`OP_FLAG_TO_BIT, 4'h2, 3'h5, 8'h00, 16'h0000, 1);
		run(`OP_DIRECT_STORE, 4'h2, 3'h0, 8'h00, 16'h0060, 1);
		chk("bit load", w, 24'h00_6020);
		run(`OP_DIRECT_LOAD, 4'h8, 3'h0, 8'h00, 16'h0060, 1);
		chk("direct load", ra, 16'h0060);
		run(`OP_DIRECT_STORE, 4'h8, 3'h0, 8'h00, 16'h0063, 1);
		chk("direct load data", w, 24'h00_6320);
	endtask
	task t_io;
		run(`OP_IMMEDIATE_LOAD, 4'h3, 3'h0, 8'h81, 16'h0000, 1);
		run(`OP_IO_OUT, 4'h3, 3'h0, 8'h00, 16'h0005, 1);
		chk("io out", iod, 8'h81);
		run(`OP_IO_BIT_SET, 4'h0, 3'h2, 8'h00, 16'h0005, 1);
		chk("io set", iod, 8'h85);
		run(`OP_IO_BIT_CLEAR, 4'h0, 3'h0, 8'h00, 16'h0005, 1);
		chk("io clear", iod, 8'h84);
		run(`OP_IO_IN, 4'h9, 3'h0, 8'h00, 16'h0005, 1);
		run(`OP_DIRECT_STORE, 4'h9, 3'h0, 8'h00, 16'h0064, 1);
		chk("io in data", w, 24'h00_6484);
		chk("io flags", status_flags_reg, 8'h40);
	endtask
	task t_ptr;
		run(`OP_IMMEDIATE_LOAD, `PTR_X_LO, 3'h0, 8'h50, 16'h0000, 1);
		run(`OP_INDIRECT_STORE, 4'h3, `PTR_POST_INC, 8'h00, 16'h0000, 1);
		chk("st x+", w, 24'h00_5081);
		run(`OP_INDIRECT_STORE, 4'h1, `PTR_PLAIN, 8'h00, 16'h0000, 1);
		chk("st x", w, 24'h00_5104);
		run(`OP_INDIRECT_STORE, 4'h3, `PTR_PRE_DEC, 8'h00, 16'h0000, 2);
		chk("st -x", w, 24'h00_5081);
		run(`OP_INDIRECT_LOAD, 4'h4, `PTR_POST_INC, 8'h00, 16'h0000, 2);
		chk("ld x+", ra, 16'h0050);
		run(`OP_INDIRECT_LOAD, 4'h5, `PTR_PRE_DEC, 8'h00, 16'h0000, 3);
		chk("ld -x", ra, 16'h0050);
		run(`OP_INDIRECT_LOAD, 4'h7, `PTR_PLAIN, 8'h00, 16'h0000, 2);
		run(`OP_DIRECT_STORE, 4'h5, 3'h0, 8'h00, 16'h0061, 1);
		chk("ld -x data", w, 24'h00_6181);
	endtask
	task t_stack;
		run(`OP_PUSH, 4'h4, 3'h0, 8'h00, 16'h0000, 2);
		chk("push", w, 24'h00_bf81);
		chk("sp push", stack_ptr, 16'h00be);
		run(`OP_POP, 4'h6, 3'h0, 8'h00, 16'h0000, 2);
		chk("sp pop", stack_ptr, 16'h00bf);
		run(`OP_DIRECT_STORE, 4'h6, 3'h0, 8'h00, 16'h0062, 1);
		chk("pop data", w, 24'h00_6281);
	endtask
	task t_ctrl;
		for (int i = 0; i < 4; i++) begin
			run(i < 3 ? `OP_BREAK + 5'(i) : `OP_IDLE, 4'h0, 3'h0, 8'h00, 16'h0000, 1);
			chk("pulses", pl, 3'h4 >> i);
			chk("ctrl flags", status_flags_reg, 8'h40);
		end
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		chk("sp reset", stack_ptr, 16'h00bf);
		chk("ready reset", op_ready, 1'b1);
		t_flags();
		t_bits();
		t_io();
		t_ptr();
		t_stack();
		t_ctrl();
		final_report();
	end
endmodule // bit_flag_and_load_store_exec_bench
`default_nettype wire
